// ===== rtl/epm_consts.svh
// constants for the exception priority map
`ifndef EPM_CONSTS_SVH
`define EPM_CONSTS_SVH

// vector positions
`define EPM_VEC_STACK_TOP   8'h00
`define EPM_VEC_RESET       8'h01
`define EPM_VEC_NMI         8'h02
`define EPM_VEC_HARD_FAULT  8'h03
`define EPM_VEC_MEM_MANAGE  8'h04
`define EPM_VEC_BUS_FAULT   8'h05
`define EPM_VEC_USAGE_FAULT 8'h06
`define EPM_VEC_SUPV_CALL   8'h0B
`define EPM_VEC_DEBUG_MON   8'h0C
`define EPM_VEC_PEND_SVC    8'h0E
`define EPM_VEC_SYS_TICK    8'h0F
`define EPM_VEC_IRQ_BASE    8'h10

// signed effective priorities, 5 bits: fixed ones sit below settable 0
`define EPM_PRI_RESET       5'h1D
`define EPM_PRI_NMI         5'h1E
`define EPM_PRI_HARD_FAULT  5'h1F
`define EPM_PRI_NONE        5'h0F
`define EPM_PRI_RESET_VAL   3'h0

// implemented interrupt lines (bits 8,9,13,26,27,30,31 reserved)
`define EPM_IRQ_IMPL_MASK   32'h33FF_DCFF

// system handler slots
`define EPM_SYS_MEM         0
`define EPM_SYS_BUS         1
`define EPM_SYS_USAGE       2
`define EPM_SYS_SVC         3
`define EPM_SYS_DBG         4
`define EPM_SYS_PEND        5
`define EPM_SYS_TICK        6

`endif

// ===== rtl/epm_pkg.sv
// types for the exception priority map
package epm_pkg;

    typedef enum logic [2:0] {
        EPM_ST_RESET  = 3'b001,
        EPM_ST_THREAD = 3'b010,
        EPM_ST_ACTIVE = 3'b100
    } epm_state_t;

    typedef struct packed {
        epm_state_t  state;
        logic [31:0] irq_pend;
        logic [6:0]  sys_pend;
        logic        nmi_pend;
        logic        hf_pend;
        logic [4:0]  cur_pri;
        logic        take_valid;
        logic [7:0]  take_vec;
        logic [4:0]  take_pri;
        logic        load_sp;
    } epm_reg_t;

endpackage

// ===== rtl/epm_exception_priority_map.sv
// exception and interrupt prioritisation for the processor core
`timescale 1ns/1ps
`include "epm_consts.svh"
module epm_exception_priority_map
    import epm_pkg::*;
#(
    parameter int NUM_IRQ = 32,
    parameter int PRI_W   = 3
)(
    // clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_nrst,
    // peripheral interrupt lines
    input  wire logic [NUM_IRQ-1:0]     i_irq,
    input  wire logic [NUM_IRQ-1:0]     i_irq_en,
    input  wire logic [NUM_IRQ*PRI_W-1:0] i_irq_pri,
    // system exception sources
    input  wire logic                   i_nmi_set_wr,
    input  wire logic                   i_mem_fault,
    input  wire logic                   i_bus_fault,
    input  wire logic                   i_bus_fault_en,
    input  wire logic                   i_mem_fault_en,
    input  wire logic                   i_usage_fault_en,
    input  wire logic                   i_usage_fault,
    input  wire logic                   i_supervisor_call,
    input  wire logic                   i_debug_mon_req,
    input  wire logic                   i_debug_mon_en,
    input  wire logic                   i_halted,
    input  wire logic                   i_pend_svc_set_wr,
    input  wire logic                   i_system_tick,
    input  wire logic [7*PRI_W-1:0]     i_sys_pri,
    // core handshake
    input  wire logic                   i_take_ack,
    input  wire logic                   i_exc_return,
    input  wire logic [4:0]             i_ret_pri,
    // to the core
    output logic                        o_take_valid,
    output logic [7:0]                  o_take_vec,
    output logic [4:0]                  o_take_pri,
    output logic [4:0]                  o_cur_pri,
    output logic                        o_load_sp,
    output logic [NUM_IRQ-1:0]          o_irq_pend
);

    // ==========================================================
    // helpers
    // ==========================================================
    // settable level widened to the signed effective scale
    function automatic logic [4:0] widen(input logic [PRI_W-1:0] p);
        widen = {{(5-PRI_W){1'b0}}, p};
    endfunction

    // signed compare: a strictly more urgent than b
    function automatic logic more_urgent(input logic [4:0] a, input logic [4:0] b);
        more_urgent = $signed(a) < $signed(b);
    endfunction

    epm_reg_t r_ff;
    epm_reg_t nxt_r;

    logic [PRI_W-1:0] sys_lvl [7];
    logic [PRI_W-1:0] irq_lvl [NUM_IRQ];
    logic [7:0]       sys_vec [7];
    logic [6:0]       sys_ok;
    logic [6:0]       sys_set;

    assign sys_vec[`EPM_SYS_MEM]   = `EPM_VEC_MEM_MANAGE;
    assign sys_vec[`EPM_SYS_BUS]   = `EPM_VEC_BUS_FAULT;
    assign sys_vec[`EPM_SYS_USAGE] = `EPM_VEC_USAGE_FAULT;
    assign sys_vec[`EPM_SYS_SVC]   = `EPM_VEC_SUPV_CALL;
    assign sys_vec[`EPM_SYS_DBG]   = `EPM_VEC_DEBUG_MON;
    assign sys_vec[`EPM_SYS_PEND]  = `EPM_VEC_PEND_SVC;
    assign sys_vec[`EPM_SYS_TICK]  = `EPM_VEC_SYS_TICK;

    // settable levels read as their reset default until the reset
    // activation has been handed over to the core
    genvar g;
    generate
        for (g = 0; g < 7; g++)
        begin : g_sys
            assign sys_lvl[g] = (r_ff.state == EPM_ST_RESET) ?
                                PRI_W'(`EPM_PRI_RESET_VAL) :
                                i_sys_pri[g*PRI_W +: PRI_W];
        end
        for (g = 0; g < NUM_IRQ; g++)
        begin : g_irq
            assign irq_lvl[g] = (r_ff.state == EPM_ST_RESET) ?
                                PRI_W'(`EPM_PRI_RESET_VAL) :
                                i_irq_pri[g*PRI_W +: PRI_W];
        end
    endgenerate

    // a fault whose handler is off or too weak escalates to hard fault
    assign sys_ok[`EPM_SYS_MEM]   = i_mem_fault_en;
    assign sys_ok[`EPM_SYS_BUS]   = i_bus_fault_en;
    assign sys_ok[`EPM_SYS_USAGE] = i_usage_fault_en;
    assign sys_ok[`EPM_SYS_SVC]   = 1'b1;
    assign sys_ok[`EPM_SYS_DBG]   = i_debug_mon_en & ~i_halted;
    assign sys_ok[`EPM_SYS_PEND]  = 1'b1;
    assign sys_ok[`EPM_SYS_TICK]  = 1'b1;

    assign sys_set[`EPM_SYS_MEM]   = i_mem_fault;
    assign sys_set[`EPM_SYS_BUS]   = i_bus_fault;
    assign sys_set[`EPM_SYS_USAGE] = i_usage_fault;
    assign sys_set[`EPM_SYS_SVC]   = i_supervisor_call;
    assign sys_set[`EPM_SYS_DBG]   = i_debug_mon_req;
    assign sys_set[`EPM_SYS_PEND]  = i_pend_svc_set_wr;
    assign sys_set[`EPM_SYS_TICK]  = i_system_tick;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        logic [4:0] best_pri;
        logic [7:0] best_vec;
        logic       found;
        logic [4:0] p;
        logic [NUM_IRQ-1:0] irq_clr;
        logic [6:0] sys_clr;
        logic       nmi_clr;
        logic       hf_clr;
        logic       fault_esc;
        logic [6:0] sys_esc;
        best_pri  = `EPM_PRI_NONE;
        best_vec  = `EPM_VEC_STACK_TOP;
        found     = 1'b0;
        p         = `EPM_PRI_NONE;
        irq_clr   = '0;
        sys_clr   = '0;
        nmi_clr   = 1'b0;
        hf_clr    = 1'b0;
        fault_esc = 1'b0;
        sys_esc   = '0;
        nxt_r     = r_ff;
        nxt_r.load_sp = 1'b0;

        // faults that cannot reach their own handler go to hard fault
        for (int i = `EPM_SYS_MEM; i <= `EPM_SYS_USAGE; i++)
        begin
            if (sys_set[i] &&
                (!sys_ok[i] || !more_urgent(widen(sys_lvl[i]), r_ff.cur_pri)))
            begin
                fault_esc  = 1'b1;
                sys_esc[i] = 1'b1;
            end
        end

        // arbitration: scan in rising vector order, strict compare keeps
        // the lower position on a tie
        if (r_ff.nmi_pend)
        begin
            best_pri = `EPM_PRI_NMI;
            best_vec = `EPM_VEC_NMI;
            found    = 1'b1;
        end
        if (r_ff.hf_pend && more_urgent(`EPM_PRI_HARD_FAULT, best_pri))
        begin
            best_pri = `EPM_PRI_HARD_FAULT;
            best_vec = `EPM_VEC_HARD_FAULT;
            found    = 1'b1;
        end
        for (int i = 0; i < 7; i++)
        begin
            p = widen(sys_lvl[i]);
            if (r_ff.sys_pend[i] && sys_ok[i] && more_urgent(p, best_pri))
            begin
                best_pri = p;
                best_vec = sys_vec[i];
                found    = 1'b1;
            end
        end
        for (int i = 0; i < NUM_IRQ; i++)
        begin
            p = widen(irq_lvl[i]);
            if (r_ff.irq_pend[i] && i_irq_en[i] && more_urgent(p, best_pri))
            begin
                best_pri = p;
                best_vec = `EPM_VEC_IRQ_BASE + 8'(i);
                found    = 1'b1;
            end
        end

        case (r_ff.state)
            EPM_ST_RESET:
            begin
                // stack top fetched before the reset handler runs
                nxt_r.load_sp    = 1'b1;
                nxt_r.take_valid = 1'b1;
                nxt_r.take_vec   = `EPM_VEC_RESET;
                nxt_r.take_pri   = `EPM_PRI_RESET;
                nxt_r.cur_pri    = `EPM_PRI_RESET;
                if (r_ff.take_valid && i_take_ack)
                begin
                    nxt_r.take_valid = 1'b0;
                    nxt_r.load_sp    = 1'b0;
                    nxt_r.cur_pri    = `EPM_PRI_NONE;
                    nxt_r.state      = EPM_ST_THREAD;
                end
            end
            EPM_ST_THREAD, EPM_ST_ACTIVE:
            begin
                if (r_ff.take_valid && i_take_ack)
                begin
                    nxt_r.cur_pri    = r_ff.take_pri;
                    nxt_r.take_valid = 1'b0;
                    nxt_r.state      = EPM_ST_ACTIVE;
                    if (r_ff.take_vec == `EPM_VEC_NMI)
                        nmi_clr = 1'b1;
                    else if (r_ff.take_vec == `EPM_VEC_HARD_FAULT)
                        hf_clr = 1'b1;
                    else if (r_ff.take_vec >= `EPM_VEC_IRQ_BASE)
                        irq_clr[5'(r_ff.take_vec - `EPM_VEC_IRQ_BASE)] = 1'b1;
                    else
                    begin
                        for (int i = 0; i < 7; i++)
                            if (sys_vec[i] == r_ff.take_vec)
                                sys_clr[i] = 1'b1;
                    end
                end
                else
                begin
                    if (i_exc_return)
                    begin
                        nxt_r.cur_pri = i_ret_pri;
                        if (i_ret_pri == `EPM_PRI_NONE)
                            nxt_r.state = EPM_ST_THREAD;
                    end
                    // offer only what would preempt; debug monitor and the
                    // rest never activate below the current level
                    nxt_r.take_valid = found && more_urgent(best_pri, r_ff.cur_pri);
                    nxt_r.take_vec   = best_vec;
                    nxt_r.take_pri   = best_pri;
                end
            end
            default:
            begin
                nxt_r.state = EPM_ST_RESET;
            end
        endcase

        // sticky pending: a new request in the take cycle survives
        nxt_r.irq_pend = (r_ff.irq_pend & ~irq_clr)
                       | (i_irq & NUM_IRQ'(`EPM_IRQ_IMPL_MASK));
        // an escalated fault is not left pending in its own slot, or it
        // would fire a second time once its handler is enabled again
        nxt_r.sys_pend = (r_ff.sys_pend & ~sys_clr) | (sys_set & ~sys_esc);
        nxt_r.nmi_pend = (r_ff.nmi_pend & ~nmi_clr) | i_nmi_set_wr;
        nxt_r.hf_pend  = (r_ff.hf_pend & ~hf_clr) | fault_esc;
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            r_ff.state      <= EPM_ST_RESET;
            r_ff.irq_pend   <= '0;
            r_ff.sys_pend   <= '0;
            r_ff.nmi_pend   <= 1'b0;
            r_ff.hf_pend    <= 1'b0;
            r_ff.cur_pri    <= `EPM_PRI_RESET;
            r_ff.take_valid <= 1'b0;
            r_ff.take_vec   <= `EPM_VEC_STACK_TOP;
            r_ff.take_pri   <= `EPM_PRI_RESET;
            r_ff.load_sp    <= 1'b0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign o_take_valid = r_ff.take_valid;
    assign o_take_vec   = r_ff.take_vec;
    assign o_take_pri   = r_ff.take_pri;
    assign o_cur_pri    = r_ff.cur_pri;
    assign o_load_sp    = r_ff.load_sp;
    assign o_irq_pend   = r_ff.irq_pend;

endmodule // epm_exception_priority_map

// ===== tb/epm_checker.sv
// port checker for the exception priority map
`timescale 1ns/1ps
`include "epm_consts.svh"
// ==========================================
// checker
module epm_checker #(
    parameter int NUM_IRQ = 32
)(
    // clock and reset
    input wire logic               i_mclk,
    input wire logic               i_nrst,
    // requests
    input wire logic [NUM_IRQ-1:0] i_irq,
    input wire logic               i_nmi_set_wr,
    input wire logic               i_take_ack,
    // offer side
    input wire logic               o_take_valid,
    input wire logic [7:0]         o_take_vec,
    input wire logic [4:0]         o_take_pri,
    input wire logic [4:0]         o_cur_pri,
    input wire logic               o_load_sp,
    input wire logic [NUM_IRQ-1:0] o_irq_pend
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    rst_hold_a: assert property (disable iff (1'b0)
        !i_nrst |=> o_cur_pri == `EPM_PRI_RESET && !o_take_valid) else $error("reset state");
    rst_offer_a: assert property ($rose(i_nrst) |=> o_take_valid && o_load_sp
        && o_take_vec == `EPM_VEC_RESET) else $error("no reset offer");
    base_level_a: assert property (o_take_valid && i_take_ack
        && o_take_vec == `EPM_VEC_RESET |=> o_cur_pri == `EPM_PRI_NONE && !o_load_sp)
        else $error("no base level after reset");
    take_drop_a: assert property (o_take_valid && i_take_ack
        && o_take_vec != `EPM_VEC_RESET |=> !o_take_valid && o_cur_pri == $past(o_take_pri))
        else $error("taken offer wrong");
    offer_hold_a: assert property (o_take_valid && !i_take_ack |=> o_take_valid)
        else $error("offer withdrawn");
    sp_load_a: assert property (o_load_sp |-> o_take_valid
        && o_take_vec == `EPM_VEC_RESET) else $error("stack load outside reset");
    rsvd_line_a: assert property ((o_irq_pend & ~`EPM_IRQ_IMPL_MASK) == 32'h0)
        else $error("reserved line pending");
    pend_latch_a: assert property (|i_irq
        |=> ($past(i_irq) & `EPM_IRQ_IMPL_MASK & ~o_irq_pend) == 32'h0) else $error("lost request");
    urgent_only_a: assert property (o_take_valid && o_take_vec != `EPM_VEC_RESET
        |-> $signed(o_take_pri) < $signed(o_cur_pri)) else $error("offer not more urgent");
    nmi_offer_a: assert property (i_nmi_set_wr && !o_take_valid
        && o_cur_pri[4:3] != 2'b11 ##1 !i_take_ack |=> o_take_valid
        && o_take_vec == `EPM_VEC_NMI) else $error("nmi not offered");
endmodule // epm_checker

bind epm_exception_priority_map epm_checker #(.NUM_IRQ(NUM_IRQ)) u_epm_checker (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_irq(i_irq), .i_nmi_set_wr(i_nmi_set_wr),
    .i_take_ack(i_take_ack), .o_take_valid(o_take_valid), .o_take_vec(o_take_vec),
    .o_take_pri(o_take_pri), .o_cur_pri(o_cur_pri), .o_load_sp(o_load_sp),
    .o_irq_pend(o_irq_pend)
);

// ===== tb/epm_core_model.sv
// core-side model that accepts offers after a chosen delay
`timescale 1ns/1ps
// ==========================================
// acceptance model
module epm_core_model (
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_nrst,
    // offer and chosen delay
    input  wire logic       i_take_valid,
    input  wire logic [2:0] i_delay,
    // acceptance
    output logic            o_take_ack
);
    logic [2:0] wait_ff;
    // ack held from one edge to the edge that takes it, then dropped
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst || !i_take_valid || o_take_ack)
        begin
            wait_ff    <= 3'h0;
            o_take_ack <= 1'b0;
        end
        else if (wait_ff == i_delay)
            o_take_ack <= 1'b1;
        else
            wait_ff <= wait_ff + 3'h1;
    end
endmodule // epm_core_model

// ===== tb/exception_priority_map_test.sv
// self-checking bench for the exception priority map
`timescale 1ns/1ps
`include "epm_consts.svh"
// ==========================================
// bench
module exception_priority_map_test;
    logic        i_mclk = 1'b0;
    logic        i_nrst = 1'b0;
    logic [31:0] i_irq = 32'h0;
    logic [95:0] i_irq_pri = 96'h0;
    logic [7:0]  ev = 8'h0;
    logic        i_mem_fault_en = 1'b1;
    logic        i_bus_fault_en = 1'b1;
    logic        i_halted = 1'b0;
    logic        i_exc_return = 1'b0;
    logic [4:0]  i_ret_pri = 5'h0F;
    logic [2:0]  delay = 3'h0;
    logic        ack, o_take_valid, o_load_sp;
    logic [7:0]  o_take_vec;
    logic [4:0]  o_take_pri, o_cur_pri;
    logic [31:0] o_irq_pend;
    int          errors = 0;
    int          checks = 0;
    // sources 32..39 are ev bits: mem, bus, usage, call, monitor, pendable, tick, nmi
    int srcs [13] = '{0, 5, 7, 18, 29, 32, 33, 34, 35, 36, 37, 38, 39};
    logic [7:0] vecs [13] = '{8'h10, 8'h15, 8'h17, 8'h22, 8'h2D,
        8'h04, 8'h05, 8'h06, 8'h0B, 8'h0C,
        8'h0E, 8'h0F, 8'h02};

    always #10 i_mclk = ~i_mclk;

    epm_exception_priority_map u_epm_exception_priority_map (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_irq(i_irq), .i_irq_en(32'hFFFF_FFFF),
        .i_irq_pri(i_irq_pri), .i_nmi_set_wr(ev[7]), .i_mem_fault(ev[0]),
        .i_bus_fault(ev[1]), .i_bus_fault_en(i_bus_fault_en), .i_mem_fault_en(i_mem_fault_en),
        .i_usage_fault_en(1'b1), .i_usage_fault(ev[2]), .i_supervisor_call(ev[3]),
        .i_debug_mon_req(ev[4]), .i_debug_mon_en(1'b1), .i_halted(i_halted),
        .i_pend_svc_set_wr(ev[5]), .i_system_tick(ev[6]), .i_sys_pri(21'h0),
        .i_take_ack(ack), .i_exc_return(i_exc_return), .i_ret_pri(i_ret_pri),
        .o_take_valid(o_take_valid), .o_take_vec(o_take_vec), .o_take_pri(o_take_pri),
        .o_cur_pri(o_cur_pri), .o_load_sp(o_load_sp), .o_irq_pend(o_irq_pend));

    epm_core_model u_epm_core_model (.i_mclk(i_mclk), .i_nrst(i_nrst),
        .i_take_valid(o_take_valid), .i_delay(delay), .o_take_ack(ack));

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // checks the offer at the falling edge while the core acknowledges it, then the new level one cycle later
    task automatic take(input logic [7:0] vec, input logic [4:0] pri, input logic [4:0] cur);
        int n;
        n = 0;
        @(negedge i_mclk);
        while (!(o_take_valid === 1'b1 && ack === 1'b1) && n < 40)
        begin
            @(negedge i_mclk);
            n++;
        end
        if (n == 40)
        begin
            errors++;
            print_verdict();
        end
        chk(o_take_vec, vec);
        chk(o_take_pri, pri);
        @(negedge i_mclk);
        chk(o_take_valid, 1'b0);
        chk(o_cur_pri, cur);
    endtask

    task automatic ret(input logic [4:0] lvl);
        @(posedge i_mclk);
        i_exc_return <= 1'b1;
        i_ret_pri    <= lvl;
        @(posedge i_mclk);
        i_exc_return <= 1'b0;
    endtask

    task automatic fire(input int s);
        @(posedge i_mclk);
        if (s < 32)
            i_irq <= 32'h1 << s;
        else
            ev <= 8'h1 << (s - 32);
        @(posedge i_mclk);
        i_irq <= 32'h0;
        ev    <= 8'h0;
    endtask

    task automatic do_reset;
        @(posedge i_mclk);
        i_nrst <= 1'b0;
        repeat (12) @(posedge i_mclk);
        i_nrst <= 1'b1;
        repeat (2) @(negedge i_mclk);
        chk(o_load_sp, 1'b1);
        take(`EPM_VEC_RESET, `EPM_PRI_RESET, `EPM_PRI_NONE);
        chk(o_load_sp, 1'b0);
        $display("reset test done");
    endtask

    initial
    begin
        do_reset();
        for (int r = 0; r < 13; r++)
        begin
            delay <= 3'(r % 5);
            fire(srcs[r]);
            if (srcs[r] == 39)
                take(vecs[r], `EPM_PRI_NMI, `EPM_PRI_NMI);
            else
                take(vecs[r], 5'h00, 5'h00);
            ret(5'h0F);
            $display("row %0d done", r);
        end
        // lines 0,1 at level 3 and line 2 at level 1 raised together
        i_irq_pri <= {87'h0, 3'h1, 3'h3, 3'h3};
        @(posedge i_mclk);
        i_irq <= 32'h7;
        @(posedge i_mclk);
        i_irq <= 32'h0;
        take(8'h12, 5'h01, 5'h01);
        repeat (4) @(negedge i_mclk);
        chk(o_take_valid, 1'b0);
        chk(o_irq_pend, 32'h3);
        fire(39);
        take(`EPM_VEC_NMI, `EPM_PRI_NMI, `EPM_PRI_NMI);
        ret(5'h01);
        ret(5'h0F);
        take(8'h10, 5'h03, 5'h03);
        ret(5'h0F);
        take(8'h11, 5'h03, 5'h03);
        ret(5'h0F);
        $display("order test done");
        i_mem_fault_en <= 1'b0;
        i_bus_fault_en <= 1'b0;
        for (int s = 32; s < 34; s++)
        begin
            fire(s);
            take(`EPM_VEC_HARD_FAULT, `EPM_PRI_HARD_FAULT, `EPM_PRI_HARD_FAULT);
            ret(5'h0F);
        end
        i_mem_fault_en <= 1'b1;
        i_bus_fault_en <= 1'b1;
        // a fault raised under the non-maskable level escalates and waits
        fire(39);
        take(`EPM_VEC_NMI, `EPM_PRI_NMI, `EPM_PRI_NMI);
        fire(34);
        repeat (4) @(negedge i_mclk);
        chk(o_take_valid, 1'b0);
        ret(5'h0F);
        take(`EPM_VEC_HARD_FAULT, `EPM_PRI_HARD_FAULT, `EPM_PRI_HARD_FAULT);
        ret(5'h0F);
        $display("escalation test done");
        // monitor while halted and a reserved line must both stay silent
        i_halted <= 1'b1;
        fire(8);
        fire(36);
        repeat (6) @(negedge i_mclk);
        chk(o_take_valid, 1'b0);
        chk(o_irq_pend, 32'h0);
        $display("silent test done");
        do_reset();
        i_halted <= 1'b0;
        print_verdict();
    end
endmodule // exception_priority_map_test
